// [hw/pmcf_top.sv]
// Power-manager clock failure, reset cause and wake cause logic with APB registers
//
// Chosen here: the APB interface to the registers.
module pmcf_top
   import pmcf_pkg::*;
(
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [PMCF_ADDR_W-1:0] paddr,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   input  wire logic                   safe_rc_clock,
   input  wire logic                   main_clk_div,
   input  wire logic                   main_clk_unavail,
   input  wire logic [2:0]             sleep_mode,
   input  wire logic                   core_supply_por_detector,
   input  wire logic                   regulator_por_detector,
   input  wire logic                   regulator_supply_monitor,
   input  wire logic                   ext_reset_n,
   input  wire logic                   wdt_reset_req,
   input  wire logic                   on_chip_debug_reset_req,
   input  wire logic [PMCF_WAKE_W-1:0] wake_event,
   output logic      [PMCF_SEL_W-1:0]  main_clock_select,
   output logic                        clock_fail_irq,
   output logic                        por_out,
   output logic                        sys_reset_out
);
   // ==========================================
   // Declarations
   logic [PMCF_SEL_W-1:0]  mcsel;
   logic [1:0]             clock_fail_ctrl;
   logic [PMCF_IRQ_W-1:0]  irq_status;
   logic [PMCF_IRQ_W-1:0]  irq_mask;
   logic [PMCF_RC_W-1:0]   reset_cause;
   logic [PMCF_WAKE_W-1:0] wake_source_record;
   logic [PMCF_RC_W-1:0]   src_q;
   logic [PMCF_RC_W-1:0]   src_now;
   logic [PMCF_RC_W-1:0]   src_new;
   logic [5:0]             pin_raw;
   logic [5:0]             pin_sync;
   logic                   rc_level;
   logic                   main_level;
   logic                   supply_low;
   logic                   ext_low;
   logic                   det_active;
   logic                   fail_pulse;
   logic                   wake_any;
   logic                   reset_event;
   logic                   wr_en;
   logic                   rd_en;
   logic                   addr_ok;
   logic                   clock_fail_detect_en;
   logic                   ext_reset_en;
   logic [PMCF_IRQ_W-1:0]  irq_set;
   logic [PMCF_IRQ_W-1:0]  irq_clr;
   logic [PMCF_WAKE_W-1:0] wake_masked;
   logic [31:0]            next_prdata;

   // ==========================================
   // Pin synchronisers
   assign pin_raw = {~ext_reset_n, regulator_supply_monitor, regulator_por_detector,
                     core_supply_por_detector, main_clk_div, safe_rc_clock};

   pmcf_sync #(
      .W (6)
   ) u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (pin_raw),
      .sync_out (pin_sync)
   );

   assign rc_level   = pin_sync[0];
   assign main_level = pin_sync[1];
   assign supply_low = pin_sync[2] | pin_sync[3] | pin_sync[4];
   assign ext_low    = pin_sync[5];

   assign clock_fail_detect_en = clock_fail_ctrl[PMCF_CF_EN_BIT];
   assign ext_reset_en         = clock_fail_ctrl[PMCF_CF_EXTEN_BIT];

   // ==========================================
   // Clock failure detector
   // Gated by detect enable
   // Suspended on RC, unavailable, stop and deep stop
   assign det_active = clock_fail_detect_en
                     & (mcsel != PMCF_SEL_RC)
                     & ~main_clk_unavail
                     & (sleep_mode != PMCF_SLEEP_STOP)
                     & (sleep_mode != PMCF_SLEEP_DSTOP);

   pmcf_cfd u_cfd (
      .pclk       (pclk),
      .presetn    (presetn),
      .active     (det_active),
      .rc_level   (rc_level),
      .main_level (main_level),
      .fail_pulse (fail_pulse)
   );

   // ==========================================
   // APB decode
   assign pready  = 1'b1;
   assign wr_en   = psel & penable & pwrite;
   assign rd_en   = psel & ~penable & ~pwrite;
   assign addr_ok = (paddr == PMCF_OFF_MCSEL)  | (paddr == PMCF_OFF_CFCTRL)
                  | (paddr == PMCF_OFF_ISTAT)  | (paddr == PMCF_OFF_IMASK)
                  | (paddr == PMCF_OFF_RESET_CAUSE) | (paddr == PMCF_OFF_WAKE);
   assign pslverr = psel & penable & ~addr_ok;

   // ==========================================
   // Main clock selection
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         mcsel <= PMCF_SEL_RST;
      else if (fail_pulse)
         mcsel <= PMCF_SEL_RC;
      else if (wr_en && paddr == PMCF_OFF_MCSEL)
         mcsel <= pwdata[PMCF_SEL_W-1:0];
   end

   assign main_clock_select = mcsel;

   // ==========================================
   // Clock failure control
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         clock_fail_ctrl <= PMCF_CFCTRL_RST;
      else if (wr_en && paddr == PMCF_OFF_CFCTRL)
         clock_fail_ctrl <= pwdata[1:0];
   end

   // ==========================================
   // Reset sources
   always_comb
   begin
      src_now                = '0;
      src_now[PMCF_RC_POR]   = supply_low;
      src_now[PMCF_RC_EXT]   = ext_low & ext_reset_en;
      src_now[PMCF_RC_WDT]   = wdt_reset_req;
      src_now[PMCF_RC_DBG]   = on_chip_debug_reset_req;
   end

   assign src_new     = src_now & ~src_q;
   assign reset_event = |src_new[PMCF_RC_W-1:1];

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         src_q <= '0;
      else
         src_q <= src_now;
   end

   // ==========================================
   // Reset outputs
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         por_out       <= 1'b0;
         sys_reset_out <= 1'b0;
      end
      else
      begin
         por_out       <= supply_low;
         sys_reset_out <= |src_now[PMCF_RC_W-1:1];
      end
   end

   // ==========================================
   // Reset cause record
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         reset_cause <= PMCF_RESET_CAUSE_RST;
      else if (|src_new)
         reset_cause <= src_new;
   end

   // ==========================================
   // Wake cause record
   // Defined bits only
   assign wake_masked = wake_event & PMCF_WAKE_MASK;
   assign wake_any    = |wake_masked;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         wake_source_record <= '0;
      else if (wake_any)
         wake_source_record <= wake_masked;
   end

   // ==========================================
   // Interrupt status and mask
   always_comb
   begin
      irq_set                 = '0;
      irq_set[PMCF_IRQ_CFAIL] = fail_pulse;
      irq_set[PMCF_IRQ_WAKE]  = wake_any;
      irq_set[PMCF_IRQ_RESET] = reset_event;
      irq_clr                 = '0;
      if (wr_en && paddr == PMCF_OFF_ISTAT)
         irq_clr = pwdata[PMCF_IRQ_W-1:0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_status <= '0;
      else
         irq_status <= (irq_status & ~irq_clr) | irq_set;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_mask <= '0;
      else if (wr_en && paddr == PMCF_OFF_IMASK)
         irq_mask <= pwdata[PMCF_IRQ_W-1:0];
   end

   assign clock_fail_irq = |(irq_status & irq_mask);

   // ==========================================
   // Read data
   always_comb
   begin
      next_prdata = 32'h00000000;
      case (paddr)
         PMCF_OFF_MCSEL:
            next_prdata[PMCF_SEL_W-1:0] = mcsel;
         PMCF_OFF_CFCTRL:
            next_prdata[1:0] = clock_fail_ctrl;
         PMCF_OFF_ISTAT:
            next_prdata[PMCF_IRQ_W-1:0] = irq_status;
         PMCF_OFF_IMASK:
            next_prdata[PMCF_IRQ_W-1:0] = irq_mask;
         PMCF_OFF_RESET_CAUSE:
            next_prdata[PMCF_RC_W-1:0] = reset_cause;
         PMCF_OFF_WAKE:
            next_prdata[PMCF_WAKE_W-1:0] = wake_source_record;
         default:
            next_prdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h00000000;
      else if (rd_en)
         prdata <= next_prdata;
   end
endmodule : pmcf_top

// [hw/pmcf_pkg.sv]
// Package: offsets, field layouts and reset values of the power-manager block
package pmcf_pkg;
   // ==========================================
   // Register map
   localparam int          PMCF_ADDR_W       = 12;
   localparam logic [11:0] PMCF_OFF_MCSEL    = 12'h000;
   localparam logic [11:0] PMCF_OFF_CFCTRL   = 12'h054;
   localparam logic [11:0] PMCF_OFF_ISTAT    = 12'h0C0;
   localparam logic [11:0] PMCF_OFF_IMASK    = 12'h0C4;
   localparam logic [11:0] PMCF_OFF_RESET_CAUSE   = 12'h180;
   localparam logic [11:0] PMCF_OFF_WAKE     = 12'h184;

   // ==========================================
   // Main clock selection field
   localparam int          PMCF_SEL_W        = 3;
   localparam logic [2:0]  PMCF_SEL_RC       = 3'h0;
   localparam logic [2:0]  PMCF_SEL_RST      = 3'h0;

   // ==========================================
   // Clock failure control bits
   localparam int          PMCF_CF_EN_BIT    = 0;
   localparam int          PMCF_CF_EXTEN_BIT = 1;
   localparam logic [1:0]  PMCF_CFCTRL_RST   = 2'h2;

   // ==========================================
   // Interrupt status bits
   localparam int          PMCF_IRQ_W        = 3;
   localparam int          PMCF_IRQ_CFAIL    = 0;
   localparam int          PMCF_IRQ_WAKE     = 1;
   localparam int          PMCF_IRQ_RESET    = 2;

   // ==========================================
   // Reset cause bits
   localparam int          PMCF_RC_W         = 4;
   localparam int          PMCF_RC_POR       = 0;
   localparam int          PMCF_RC_EXT       = 1;
   localparam int          PMCF_RC_WDT       = 2;
   localparam int          PMCF_RC_DBG       = 3;
   localparam logic [3:0]  PMCF_RESET_CAUSE_RST   = 4'h1;

   // ==========================================
   // Wake cause layout and sleep modes
   localparam int          PMCF_WAKE_W       = 18;
   localparam logic [17:0] PMCF_WAKE_MASK    = 18'h3007F;
   localparam logic [2:0]  PMCF_SLEEP_STOP   = 3'h4;
   localparam logic [2:0]  PMCF_SLEEP_DSTOP  = 3'h5;

   // ==========================================
   // Detector states
   typedef enum logic [1:0] {
      PMCF_DET_IDLE  = 2'b00,
      PMCF_DET_ARM   = 2'b01,
      PMCF_DET_WATCH = 2'b10
   } pmcf_det_t;
endpackage : pmcf_pkg

// [hw/pmcf_sync.sv]
// Three-stage pin synchroniser with agreement filter
module pmcf_sync
   import pmcf_pkg::*;
#(
   parameter int W = 1
)(
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   // ==========================================
   // Per-bit synchroniser
   genvar i;
   generate
      for (i = 0; i < W; i++)
      begin : g_bit
         logic s1;
         logic s2;
         logic s3;
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               s1          <= 1'b0;
               s2          <= 1'b0;
               s3          <= 1'b0;
               sync_out[i] <= 1'b0;
            end
            else
            begin
               s1 <= async_in[i];
               s2 <= s1;
               s3 <= s2;
               if (s2 == s3)
                  sync_out[i] <= s3;
            end
         end
      end
   endgenerate
endmodule : pmcf_sync

// [hw/pmcf_cfd.sv]
// Clock failure detector: divided main clock watched against the RC clock
module pmcf_cfd
   import pmcf_pkg::*;
(
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic active,
   input  wire logic rc_level,
   input  wire logic main_level,
   output logic      fail_pulse
);
   logic      rc_q;
   logic      main_q;
   logic      rc_rise;
   logic      main_rise;
   logic      seen;
   pmcf_det_t state;
   pmcf_det_t next_state;

   assign rc_rise   = rc_level & ~rc_q;
   assign main_rise = main_level & ~main_q;

   // ==========================================
   // Edge history
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rc_q   <= 1'b0;
         main_q <= 1'b0;
      end
      else
      begin
         rc_q   <= rc_level;
         main_q <= main_level;
      end
   end

   // ==========================================
   // State machine
   always_comb
   begin
      next_state = state;
      case (state)
         PMCF_DET_IDLE:
            if (active)
               next_state = PMCF_DET_ARM;
         PMCF_DET_ARM:
            if (!active)
               next_state = PMCF_DET_IDLE;
            else if (rc_rise)
               next_state = PMCF_DET_WATCH;
         PMCF_DET_WATCH:
            if (!active)
               next_state = PMCF_DET_IDLE;
         default:
            next_state = PMCF_DET_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state <= PMCF_DET_IDLE;
      else
         state <= next_state;
   end

   // ==========================================
   // Edge within RC period
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         seen       <= 1'b0;
         fail_pulse <= 1'b0;
      end
      else
      begin
         fail_pulse <= (state == PMCF_DET_WATCH) & active & rc_rise & ~seen & ~main_rise;
         if (rc_rise || state != PMCF_DET_WATCH)
            seen <= 1'b0;
         else if (main_rise)
            seen <= 1'b1;
      end
   end
endmodule : pmcf_cfd

// [bench/pmcf_monitor.sv]
// Checker: port-level assertions for the power-manager block
module pmcf_monitor
   import pmcf_pkg::*;
(
   input wire logic                   pclk,
   input wire logic                   presetn,
   input wire logic                   psel,
   input wire logic                   penable,
   input wire logic                   pwrite,
   input wire logic [PMCF_ADDR_W-1:0] paddr,
   input wire logic [31:0]            pwdata,
   input wire logic                   pslverr,
   input wire logic                   main_clk_unavail,
   input wire logic [2:0]             sleep_mode,
   input wire logic                   core_supply_por_detector,
   input wire logic                   regulator_por_detector,
   input wire logic                   regulator_supply_monitor,
   input wire logic                   ext_reset_n,
   input wire logic                   wdt_reset_req,
   input wire logic                   on_chip_debug_reset_req,
   input wire logic [PMCF_SEL_W-1:0]  main_clock_select,
   input wire logic                   por_out,
   input wire logic                   sys_reset_out
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ==========
   // Helpers
   logic acc;
   logic mapped;
   logic sel_wr;
   logic low;
   logic hold;
   logic ext_en;
   assign acc = psel && penable;
   assign mapped = paddr inside {PMCF_OFF_MCSEL, PMCF_OFF_CFCTRL, PMCF_OFF_ISTAT,
                                 PMCF_OFF_IMASK, PMCF_OFF_RESET_CAUSE, PMCF_OFF_WAKE};
   assign sel_wr = acc && pwrite && (paddr == PMCF_OFF_MCSEL);
   assign low = core_supply_por_detector || regulator_por_detector || regulator_supply_monitor;
   assign hold = main_clk_unavail || sleep_mode inside {PMCF_SLEEP_STOP, PMCF_SLEEP_DSTOP};
   // Pin reset enable as last written
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ext_en <= PMCF_CFCTRL_RST[PMCF_CF_EXTEN_BIT];
      else if (acc && pwrite && paddr == PMCF_OFF_CFCTRL)
         ext_en <= pwdata[PMCF_CF_EXTEN_BIT];
   end
   sequence s_low8;
      low [*8];
   endsequence
   sequence s_hold5;
      hold [*5];
   endsequence
   // ==========
   // Assertions
   a_unmapped_err: assert property (acc && !mapped |-> pslverr)
      else $error("unmapped access without error");
   a_mapped_ok: assert property (acc && mapped |-> !pslverr)
      else $error("mapped access flagged as error");
   a_por_low: assert property (s_low8 |-> por_out)
      else $error("power-on reset low while a supply is low");
   a_por_clear: assert property (!low [*8] |-> !por_out)
      else $error("power-on reset high with all supplies good");
   a_ext_reset: assert property ((ext_en && !ext_reset_n) [*8] |-> sys_reset_out)
      else $error("reset pin low without system reset");
   a_ext_masked: assert property (!ext_en && !wdt_reset_req
      && !on_chip_debug_reset_req |=> !sys_reset_out)
      else $error("system reset from a disabled reset pin");
   a_req_reset: assert property ((wdt_reset_req || on_chip_debug_reset_req)
      |-> ##[1:2] sys_reset_out)
      else $error("reset request without system reset");
   a_sel_change: assert property ($changed(main_clock_select)
      |-> main_clock_select == PMCF_SEL_RC || $past(sel_wr))
      else $error("clock select moved to a non-RC value by itself");
   a_no_watch: assert property (s_hold5 |-> $stable(main_clock_select) || $past(sel_wr))
      else $error("clock select changed while monitoring is suspended");
endmodule : pmcf_monitor

bind pmcf_top pmcf_monitor mon_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .pslverr, .main_clk_unavail, .sleep_mode, .core_supply_por_detector,
   .regulator_por_detector, .regulator_supply_monitor, .ext_reset_n, .wdt_reset_req,
   .on_chip_debug_reset_req, .main_clock_select, .por_out, .sys_reset_out);

// [bench/pmcf_partner.sv]
// Model of the oscillators, supply detectors and reset pin
module pmcf_partner
(
   input  wire logic       main_run,
   input  wire logic [2:0] supply_low,
   input  wire logic       ext_req,
   output logic            safe_rc_clock,
   output logic            main_clk_div,
   output logic            core_supply_por_detector,
   output logic            regulator_por_detector,
   output logic            regulator_supply_monitor,
   output logic            ext_reset_n
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========
   // Free-running RC oscillator
   initial
   begin
      safe_rc_clock = 1'b0;
      // Offset keeps pin changes off the sampling edge
      #7;
      forever #530 safe_rc_clock = ~safe_rc_clock;
   end
   // ==========
   // Divided main clock, freezes when stopped
   initial
   begin
      main_clk_div = 1'b0;
      #20;
      forever #350 main_clk_div = main_run ? ~main_clk_div : main_clk_div;
   end
   assign core_supply_por_detector = supply_low[0];
   assign regulator_por_detector   = supply_low[1];
   assign regulator_supply_monitor = supply_low[2];
   assign ext_reset_n              = ~ext_req;
endmodule : pmcf_partner

// [bench/pmcf_tb_top.sv]
// Self-checking testbench for the power-manager block
`define CHK(nm, exp, got) \
   begin \
      n_compared++; \
      if ((got) !== (exp)) \
      begin \
         errors++; \
         $display("ERROR %s expected %h seen %h", nm, exp, got); \
      end \
   end
module pmcf_tb_top
   import pmcf_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0]  sleep_mode, supply_low, rq, main_clock_select;
   logic [17:0] wake_event;
   logic        main_run, main_clk_unavail, safe_rc_clock, main_clk_div, ext_reset_n;
   logic        core_p, reg_p, mon_p, clock_fail_irq, por_out, sys_reset_out;
   int          errors = 0, n_compared = 0, cycles = 0;

   pmcf_partner part_u (.main_run, .supply_low, .ext_req(rq[0]), .safe_rc_clock,
      .main_clk_div, .core_supply_por_detector(core_p), .regulator_por_detector(reg_p),
      .regulator_supply_monitor(mon_p), .ext_reset_n);
   pmcf_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .safe_rc_clock, .main_clk_div, .main_clk_unavail, .sleep_mode,
      .core_supply_por_detector(core_p), .regulator_por_detector(reg_p),
      .regulator_supply_monitor(mon_p), .ext_reset_n, .wdt_reset_req(rq[1]),
      .on_chip_debug_reset_req(rq[2]), .wake_event, .main_clock_select, .clock_fail_irq,
      .por_out, .sys_reset_out);

   // ==========
   // Clock and timeout
   initial
   begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   always @(posedge pclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         errors++;
         print_verdict();
      end
   end

   // ==========
   // Common tasks
   task automatic print_verdict();
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : print_verdict
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : cyc
   task automatic do_reset();
      presetn <= 1'b0;
      cyc(6);
      presetn <= 1'b1;
   endtask : do_reset
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd      = prdata;
      slverr  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic chk_rd(input string nm, input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(nm, e, rd)
   endtask : chk_rd
   task automatic chk_irq(input string nm, input logic e);
      cyc(1);
      `CHK(nm, e, clock_fail_irq)
   endtask : chk_irq

   // ==========
   // Scenarios
   task automatic t_regs();
      logic [11:0] ad [7] = '{PMCF_OFF_MCSEL, PMCF_OFF_CFCTRL, PMCF_OFF_ISTAT,
                              PMCF_OFF_IMASK, PMCF_OFF_WAKE, PMCF_OFF_RESET_CAUSE, 12'h010};
      logic [31:0] ex [7] = '{32'h0, {30'h0, PMCF_CFCTRL_RST}, 32'h0, 32'h0, 32'h0, 32'h1, 32'h0};
      for (int i = 0; i < 7; i++)
         chk_rd("reset value", ad[i], ex[i]);
      `CHK("unmapped error", 1'b1, slverr)
      apb(1'b1, PMCF_OFF_RESET_CAUSE, 32'hF);
      apb(1'b1, 12'h010, 32'hFFFFFFFF);
      chk_rd("cause read-only", PMCF_OFF_RESET_CAUSE, 32'h1);
   endtask : t_regs
   task automatic t_cfail();
      apb(1'b1, PMCF_OFF_IMASK, 32'h1);
      apb(1'b1, PMCF_OFF_MCSEL, 32'h3);
      apb(1'b1, PMCF_OFF_CFCTRL, 32'h3);
      cyc(60);
      `CHK("sel main running", 3'h3, main_clock_select)
      main_run <= 1'b0;
      for (int i = 0; i < 40 && main_clock_select !== PMCF_SEL_RC; i++)
         @(posedge pclk);
      `CHK("sel after fail", PMCF_SEL_RC, main_clock_select)
      chk_rd("sel reg after fail", PMCF_OFF_MCSEL, 32'h0);
      chk_rd("status after fail", PMCF_OFF_ISTAT, 32'h1);
      chk_irq("irq after fail", 1'b1);
      apb(1'b1, PMCF_OFF_ISTAT, 32'h1);
      chk_irq("irq cleared", 1'b0);
      main_run <= 1'b1;
   endtask : t_cfail
   task automatic t_suspend();
      for (int k = 0; k < 4; k++)
      begin
         apb(1'b1, PMCF_OFF_MCSEL, 32'h5);
         apb(1'b1, PMCF_OFF_CFCTRL, k == 0 ? 32'h2 : 32'h3);
         main_clk_unavail <= (k == 1);
         sleep_mode <= k == 2 ? PMCF_SLEEP_STOP : k == 3 ? PMCF_SLEEP_DSTOP : 3'h0;
         cyc(2);
         main_run <= 1'b0;
         cyc(80);
         `CHK("sel suspended", 3'h5, main_clock_select)
         main_run <= 1'b1;
         cyc(40);
         main_clk_unavail <= 1'b0;
         sleep_mode <= 3'h0;
         cyc(40);
         `CHK("sel resumed", 3'h5, main_clock_select)
      end
   endtask : t_suspend
   task automatic t_wake();
      int wb [9] = '{0, 1, 2, 3, 4, 5, 6, 16, 17};
      for (int i = 0; i < 9; i++)
      begin
         wake_event <= (18'h1 << wb[i]) | 18'h00400;
         cyc(1);
         wake_event <= 18'h0;
         cyc(2);
         chk_rd("wake cause", PMCF_OFF_WAKE, 32'h1 << wb[i]);
      end
      chk_irq("irq masked", 1'b0);
      apb(1'b1, PMCF_OFF_IMASK, 32'h2);
      chk_irq("irq unmasked", 1'b1);
      apb(1'b1, PMCF_OFF_ISTAT, 32'h2);
      chk_irq("irq wake cleared", 1'b0);
   endtask : t_wake
   task automatic t_reset();
      for (int i = 0; i < 3; i++)
      begin
         rq <= 3'h1 << i;
         cyc(10);
         `CHK("system reset", 1'b1, sys_reset_out)
         rq <= 3'h0;
         cyc(10);
         `CHK("system reset released", 1'b0, sys_reset_out)
         chk_rd("reset cause", PMCF_OFF_RESET_CAUSE, 32'h1 << (PMCF_RC_EXT + i));
         chk_rd("wake kept", PMCF_OFF_WAKE, 32'h20000);
      end
      apb(1'b1, PMCF_OFF_CFCTRL, 32'h1);
      rq <= 3'h1;
      cyc(10);
      `CHK("pin reset disabled", 1'b0, sys_reset_out)
      rq <= 3'h0;
      cyc(10);
      chk_rd("cause pin disabled", PMCF_OFF_RESET_CAUSE, 32'h8);
      apb(1'b1, PMCF_OFF_CFCTRL, 32'h3);
      chk_rd("status reset", PMCF_OFF_ISTAT, 32'h4);
   endtask : t_reset
   task automatic t_por();
      for (int i = 0; i < 3; i++)
      begin
         supply_low <= 3'h1 << i;
         cyc(10);
         `CHK("por while low", 1'b1, por_out)
         supply_low <= 3'h0;
         cyc(10);
         `CHK("por released", 1'b0, por_out)
      end
      do_reset();
      chk_rd("cause after por", PMCF_OFF_RESET_CAUSE, 32'h1);
      chk_rd("wake after por", PMCF_OFF_WAKE, 32'h0);
   endtask : t_por

   // ==========
   // Main sequence
   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      sleep_mode = 3'h0;
      supply_low = 3'h0;
      rq = 3'h0;
      wake_event = 18'h0;
      main_run = 1'b1;
      main_clk_unavail = 1'b0;
      do_reset();
      t_regs();
      t_cfail();
      t_suspend();
      t_wake();
      t_reset();
      t_por();
      print_verdict();
   end
endmodule : pmcf_tb_top
